// File: dcd_consts.vh
/*
  Constants of the dual channel decimation path: register offsets, field
  positions, reset values, codes and timing figures.
  Assumes inclusion by its bare name from the design files; definitions only.
*/
// What this block does
// R01 - two independent channels, current and voltage/temperature, same chain, run together
// R02 - decimating low-pass removes quantisation noise, gives a 16-bit result word
// R03 - first decimation stage ratio is selectable, 64 or 128, per channel
// R04 - optional second decimation stage lowers output rate further
// R05 - chopping and de-chopping on after reset; a register bit turns both off
// R06 - optional FIR low-pass stage selectable in the output path
// R07 - output rate follows sampling rate and ratios, 1 Hz to 2 kHz reachable
// R08 - current channel: first valid result two conversion cycles after enable
// R09 - voltage channel: first valid result two conversion cycles after enable, any input
// R10 - second channel input multiplexer picks one of four sources
// R11 - external temperature converts sensor input, then resistor input, one at a time
// R12 - amplifier gain per channel selectable from 1, 5, 25, 40, 100
// R13 - software should use only gain 5 or 25 for automotive battery voltage
// R14 - each channel takes a 1-bit bitstream with its oversampling clock
// R15 - de-chop clock divided from oversampling clock, 2 kHz or 4 kHz
// R16 - second stage ratio is a power of two from 1 to 32768
// R17 - moving average alternative over 1, 3, 7 or 15 samples
// R18 - each new result gets a one-cycle valid strobe and holds until replaced
// R19 - multiplexer change restarts second channel first-result latency
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH

`define DCD_ADDR_CTRL 8'h00
`define DCD_ADDR_CFG_I 8'h04
`define DCD_ADDR_CFG_V 8'h08
`define DCD_ADDR_STATUS 8'h0c
`define DCD_ADDR_RESULT_I 8'h10
`define DCD_ADDR_RESULT_V 8'h14

`define DCD_CTRL_EN_I 0
`define DCD_CTRL_EN_V 1
`define DCD_CTRL_CHOP_EN 2
`define DCD_CTRL_CHOP_4K 3
`define DCD_CTRL_MUX_LSB 4
`define DCD_CTRL_MUX_MSB 5
`define DCD_CTRL_RESET 6'h04

`define DCD_CFG_R1_128 0
`define DCD_CFG_R2_LSB 1
`define DCD_CFG_R2_MSB 4
`define DCD_CFG_POST_LSB 5
`define DCD_CFG_POST_MSB 6
`define DCD_CFG_MA_LSB 7
`define DCD_CFG_MA_MSB 8
`define DCD_CFG_GAIN_LSB 9
`define DCD_CFG_GAIN_MSB 11
`define DCD_CFG_RESET 12'h000

`define DCD_GAIN_CODE_MAX 3'h4

`define DCD_MUX_BATTERY 2'h0
`define DCD_MUX_EXT_TEMP 2'h1
`define DCD_MUX_EXT_REF 2'h2
`define DCD_MUX_INT_TEMP 2'h3

`define DCD_POST_NONE 2'h0
`define DCD_POST_MA 2'h1
`define DCD_POST_FIR 2'h2

`define DCD_MA_RECIP_1 18'h1_0000
`define DCD_MA_RECIP_3 18'h0_5555
`define DCD_MA_RECIP_7 18'h0_2492
`define DCD_MA_RECIP_15 18'h0_1111

`define DCD_R1_LAST_64 7'h3f
`define DCD_R1_LAST_128 7'h7f

`define DCD_FIRST_RESULT_SKIP 2'h2

`define DCD_OVERSAMPLE_CLOCK_HZ 1000000
`define DCD_CHOP_LO_HZ 2000
`define DCD_CHOP_HI_HZ 4000

`endif

// File: dcd_hist_mem.v
/*
  Small sample history memory: one write port, one read port with the read
  data held in a register.
  Assumes the user keeps track of which words were ever written.
*/
`timescale 1ns/1ps
module dcd_hist_mem #(
  parameter WIDTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are qualified by a fill count upstream
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: dcd_top.v
/*
  Dual channel decimation path with an APB register slave: bitstream input,
  CIC first stage, de-chopper, power-of-two second stage, optional moving
  average or FIR, 16-bit results with valid strobes.
  Assumes modulator bitstreams and oversample_clock are synchronous to clk
  and that oversample_clock runs well below clk/2.
*/
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_top #(
  parameter OVERSAMPLE_CLOCK_HZ = `DCD_OVERSAMPLE_CLOCK_HZ
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire oversample_clock,
  input wire [1:0] modulator_bitstream,
  output reg dechop_clock,
  output wire [2:0] pga_gain_i,
  output wire [2:0] pga_gain_v,
  output wire [1:0] mux_sel,
  output reg ext_temp_resistor_sel,
  output reg temp_current_en,
  output wire [15:0] result_i,
  output wire [15:0] result_v,
  output wire result_i_valid,
  output wire result_v_valid
);
  localparam integer CHOP_HALF_LO = OVERSAMPLE_CLOCK_HZ / (2 * `DCD_CHOP_LO_HZ);
  localparam integer CHOP_HALF_HI = OVERSAMPLE_CLOCK_HZ / (2 * `DCD_CHOP_HI_HZ);

  reg [5:0] ctrl_reg;
  reg [11:0] cfg_i_reg;
  reg [11:0] cfg_v_reg;
  reg os_prev_reg;
  reg [15:0] chop_cnt_reg;
  reg chop_phase_reg;
  reg [1:0] mux_prev_reg;
  reg sub_toggle_reg;
  reg res_sub_reg;

  wire [31:0] res_all;
  wire [1:0] valid_all;
  wire [1:0] ready_all;
  wire [1:0] publish_all;

  wire chop_en = ctrl_reg[`DCD_CTRL_CHOP_EN];
  wire os_tick = oversample_clock & ~os_prev_reg; // R14
  wire [15:0] chop_half = ctrl_reg[`DCD_CTRL_CHOP_4K] ? CHOP_HALF_HI[15:0] : CHOP_HALF_LO[15:0];
  wire is_ext_temp = (mux_sel == `DCD_MUX_EXT_TEMP);
  wire v_restart = (mux_sel != mux_prev_reg) | sub_toggle_reg; // R19
  wire [1:0] chan_restart = {v_restart, 1'b0};

  assign mux_sel = ctrl_reg[`DCD_CTRL_MUX_MSB:`DCD_CTRL_MUX_LSB]; // R10
  assign pga_gain_i = cfg_i_reg[`DCD_CFG_GAIN_MSB:`DCD_CFG_GAIN_LSB]; // R12
  assign pga_gain_v = cfg_v_reg[`DCD_CFG_GAIN_MSB:`DCD_CFG_GAIN_LSB]; // R12
  assign result_i = res_all[15:0];
  assign result_v = res_all[31:16];
  assign result_i_valid = valid_all[0];
  assign result_v_valid = valid_all[1];

  function [15:0] dcd_sat;
    input [31:0] v;
    begin
      if (!v[31] && (v[30:15] != 16'h0000)) begin
        dcd_sat = 16'h7fff;
      end else if (v[31] && (v[30:15] != 16'hffff)) begin
        dcd_sat = 16'h8000;
      end else begin
        dcd_sat = v[15:0];
      end
    end
  endfunction

  // apb slave: one wait state, data and error answered with pready
  wire apb_acc = psel & penable;
  wire addr_hit = (paddr == `DCD_ADDR_CTRL) || (paddr == `DCD_ADDR_CFG_I) ||
                  (paddr == `DCD_ADDR_CFG_V) || (paddr == `DCD_ADDR_STATUS) ||
                  (paddr == `DCD_ADDR_RESULT_I) || (paddr == `DCD_ADDR_RESULT_V);
  wire apb_wr = apb_acc & pready & pwrite & addr_hit;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `DCD_ADDR_CTRL: rd_mux = {26'h000_0000, ctrl_reg};
      `DCD_ADDR_CFG_I: rd_mux = {20'h0_0000, cfg_i_reg};
      `DCD_ADDR_CFG_V: rd_mux = {20'h0_0000, cfg_v_reg};
      `DCD_ADDR_STATUS: rd_mux = {28'h000_0000, chop_phase_reg, res_sub_reg, ready_all};
      `DCD_ADDR_RESULT_I: rd_mux = {16'h0000, res_all[15:0]};
      `DCD_ADDR_RESULT_V: rd_mux = {16'h0000, res_all[31:16]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // a gain code outside the five settings is refused, the old gain stays
  function [11:0] dcd_cfg_write;
    input [11:0] old;
    input [31:0] wd;
    begin
      dcd_cfg_write = wd[11:0];
      if (wd[`DCD_CFG_GAIN_MSB:`DCD_CFG_GAIN_LSB] > `DCD_GAIN_CODE_MAX) begin
        dcd_cfg_write[`DCD_CFG_GAIN_MSB:`DCD_CFG_GAIN_LSB] =
          old[`DCD_CFG_GAIN_MSB:`DCD_CFG_GAIN_LSB]; // R12
      end
    end
  endfunction

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_reg <= `DCD_CTRL_RESET; // R05
      cfg_i_reg <= `DCD_CFG_RESET;
      cfg_v_reg <= `DCD_CFG_RESET;
    end else begin
      pready <= apb_acc & ~pready;
      if (apb_acc & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_hit;
      end
      if (apb_wr && (paddr == `DCD_ADDR_CTRL)) begin
        ctrl_reg <= pwdata[5:0]; // R05
      end
      if (apb_wr && (paddr == `DCD_ADDR_CFG_I)) begin
        cfg_i_reg <= dcd_cfg_write(cfg_i_reg, pwdata); // R07
      end
      if (apb_wr && (paddr == `DCD_ADDR_CFG_V)) begin
        cfg_v_reg <= dcd_cfg_write(cfg_v_reg, pwdata); // R07
      end
    end
  end

  // de-chop clock divider, counted in oversampling edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      os_prev_reg <= 1'b0;
      chop_cnt_reg <= 16'h0000;
      chop_phase_reg <= 1'b0;
      dechop_clock <= 1'b0;
    end else begin
      os_prev_reg <= oversample_clock;
      if (os_tick) begin
        if (chop_cnt_reg >= chop_half - 16'h0001) begin
          chop_cnt_reg <= 16'h0000; // R15
          chop_phase_reg <= ~chop_phase_reg;
        end else begin
          chop_cnt_reg <= chop_cnt_reg + 16'h0001;
        end
      end
      dechop_clock <= chop_en & chop_phase_reg; // R05
    end
  end

  // external temperature: alternate sensor and resistor input per result
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_prev_reg <= `DCD_MUX_BATTERY;
      sub_toggle_reg <= 1'b0;
      ext_temp_resistor_sel <= 1'b0;
      res_sub_reg <= 1'b0;
      temp_current_en <= 1'b0;
    end else begin
      mux_prev_reg <= mux_sel;
      sub_toggle_reg <= publish_all[1] & is_ext_temp; // R11
      temp_current_en <= ctrl_reg[`DCD_CTRL_EN_V] & is_ext_temp; // R11
      if (publish_all[1]) begin
        res_sub_reg <= ext_temp_resistor_sel;
      end
      if (!is_ext_temp || !ctrl_reg[`DCD_CTRL_EN_V]) begin
        ext_temp_resistor_sel <= 1'b0;
      end else if (sub_toggle_reg) begin
        ext_temp_resistor_sel <= ~ext_temp_resistor_sel; // R11
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan // R01
      wire [11:0] cfg = (c == 0) ? cfg_i_reg : cfg_v_reg;
      wire en = ctrl_reg[c];
      wire clr = ~en | chan_restart[c];
      wire r1_128 = cfg[`DCD_CFG_R1_128];
      wire [3:0] r2_log = cfg[`DCD_CFG_R2_MSB:`DCD_CFG_R2_LSB];
      wire [1:0] post = cfg[`DCD_CFG_POST_MSB:`DCD_CFG_POST_LSB];
      wire [1:0] ma_sel = cfg[`DCD_CFG_MA_MSB:`DCD_CFG_MA_LSB];
      wire [6:0] r1_last = r1_128 ? `DCD_R1_LAST_128 : `DCD_R1_LAST_64; // R03
      wire [15:0] r2_last = (16'h0001 << r2_log) - 16'h0001; // R16
      wire [4:0] ma_n5 = (5'h02 << ma_sel) - 5'h01;
      wire [3:0] ma_n = ma_n5[3:0]; // R17
      reg signed [23:0] int1_reg;
      reg signed [23:0] int2_reg;
      reg signed [23:0] dly1_reg;
      reg signed [23:0] dly2_reg;
      reg [6:0] r1_cnt_reg;
      reg signed [31:0] acc_reg;
      reg [15:0] r2_cnt_reg;
      reg [1:0] st_reg;
      reg [15:0] x_reg;
      reg [15:0] h1_reg;
      reg [15:0] h2_reg;
      reg [15:0] h3_reg;
      reg [3:0] wptr_reg;
      reg [3:0] fill_reg;
      reg signed [19:0] sum_reg;
      reg signed [37:0] prod_reg;
      reg [1:0] skip_reg;
      reg [15:0] result_reg;
      reg valid_reg;
      reg [17:0] recip;
      wire [15:0] mem_rdata;
      wire signed [23:0] xin = modulator_bitstream[c] ? 24'h00_0001 : 24'hff_ffff;
      wire signed [23:0] comb1 = int2_reg - dly1_reg;
      wire signed [23:0] comb2 = comb1 - dly2_reg;
      wire signed [31:0] cic1_ext = {{8{comb2[23]}}, comb2};
      // scale to 16-bit full scale: R^2 gain is 4096 or 16384
      wire signed [31:0] cic1_scaled = r1_128 ? (cic1_ext <<< 1) : (cic1_ext <<< 3);
      // de-chop uses the phase at output time; a small skew is traded for no extra delay
      wire signed [31:0] dechopped = (chop_en & chop_phase_reg) ? -cic1_scaled : cic1_scaled;
      wire [15:0] s1 = dcd_sat(dechopped); // R02
      wire r1_done = os_tick & (r1_cnt_reg == r1_last);
      wire signed [31:0] acc_total = acc_reg + {{16{s1[15]}}, s1};
      wire signed [31:0] s2_wide = acc_total >>> r2_log; // R04
      wire s2_valid = r1_done & (r2_cnt_reg == r2_last);
      wire [15:0] s2 = dcd_sat(s2_wide);
      wire [15:0] old = (fill_reg >= ma_n) ? mem_rdata : 16'h0000;
      wire signed [31:0] xe = {{16{x_reg[15]}}, x_reg};
      wire signed [31:0] h1e = {{16{h1_reg[15]}}, h1_reg};
      wire signed [31:0] h2e = {{16{h2_reg[15]}}, h2_reg};
      wire signed [31:0] h3e = {{16{h3_reg[15]}}, h3_reg};
      wire signed [31:0] fir_sum = xe + (h1e <<< 1) + h1e + (h2e <<< 1) + h2e + h3e;
      wire [15:0] fir_out = dcd_sat(fir_sum >>> 3); // R06
      wire [15:0] ma_out = dcd_sat({{10{prod_reg[37]}}, prod_reg[37:16]}); // R17
      wire publish = (st_reg == 2'h3) & (skip_reg == `DCD_FIRST_RESULT_SKIP);

      always @* begin
        recip = `DCD_MA_RECIP_1;
        case (ma_sel)
          2'h0: recip = `DCD_MA_RECIP_1;
          2'h1: recip = `DCD_MA_RECIP_3;
          2'h2: recip = `DCD_MA_RECIP_7;
          2'h3: recip = `DCD_MA_RECIP_15;
          default: recip = `DCD_MA_RECIP_1;
        endcase
      end

      dcd_hist_mem #(
        .WIDTH(16),
        .AW(4)
      ) u_hist (
        .clk(clk),
        .we(s2_valid & ~clr),
        .waddr(wptr_reg),
        .wdata(s2),
        .raddr(wptr_reg - ma_n),
        .rdata(mem_rdata)
      );

      // cic1 and cic2; changing the moving average length needs a re-enable
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          int1_reg <= 24'h00_0000;
          int2_reg <= 24'h00_0000;
          dly1_reg <= 24'h00_0000;
          dly2_reg <= 24'h00_0000;
          r1_cnt_reg <= 7'h00;
          acc_reg <= 32'h0000_0000;
          r2_cnt_reg <= 16'h0000;
        end else if (clr) begin
          int1_reg <= 24'h00_0000;
          int2_reg <= 24'h00_0000;
          dly1_reg <= 24'h00_0000;
          dly2_reg <= 24'h00_0000;
          r1_cnt_reg <= 7'h00;
          acc_reg <= 32'h0000_0000;
          r2_cnt_reg <= 16'h0000;
        end else if (os_tick) begin
          int1_reg <= int1_reg + xin; // R14
          int2_reg <= int2_reg + int1_reg;
          r1_cnt_reg <= r1_done ? 7'h00 : r1_cnt_reg + 7'h01; // R03
          if (r1_done) begin
            dly1_reg <= int2_reg;
            dly2_reg <= comb1;
            acc_reg <= s2_valid ? 32'h0000_0000 : acc_total; // R16
            r2_cnt_reg <= s2_valid ? 16'h0000 : r2_cnt_reg + 16'h0001;
          end
        end
      end

      // post filter sequence: 0 idle, 1 history read, 2 multiply, 3 publish
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          st_reg <= 2'h0;
          x_reg <= 16'h0000;
          h1_reg <= 16'h0000;
          h2_reg <= 16'h0000;
          h3_reg <= 16'h0000;
          wptr_reg <= 4'h0;
          fill_reg <= 4'h0;
          sum_reg <= 20'h0_0000;
          prod_reg <= 38'h00_0000_0000;
          skip_reg <= 2'h0;
          result_reg <= 16'h0000;
          valid_reg <= 1'b0;
        end else begin
          valid_reg <= 1'b0;
          if (clr) begin
            st_reg <= 2'h0;
            h1_reg <= 16'h0000;
            h2_reg <= 16'h0000;
            h3_reg <= 16'h0000;
            wptr_reg <= 4'h0;
            fill_reg <= 4'h0;
            sum_reg <= 20'h0_0000;
            skip_reg <= 2'h0; // R08 R09 R19
          end else begin
            case (st_reg)
              2'h0: begin
                if (s2_valid) begin
                  x_reg <= s2;
                  st_reg <= 2'h1;
                end
              end
              2'h1: begin
                sum_reg <= sum_reg + {{4{x_reg[15]}}, x_reg} - {{4{old[15]}}, old};
                fill_reg <= (fill_reg == 4'hf) ? fill_reg : fill_reg + 4'h1;
                wptr_reg <= wptr_reg + 4'h1;
                st_reg <= 2'h2;
              end
              2'h2: begin
                prod_reg <= sum_reg * $signed(recip); // R17
                st_reg <= 2'h3;
              end
              2'h3: begin
                h3_reg <= h2_reg;
                h2_reg <= h1_reg;
                h1_reg <= x_reg;
                st_reg <= 2'h0;
                if (skip_reg != `DCD_FIRST_RESULT_SKIP) begin
                  skip_reg <= skip_reg + 2'h1; // R08 R09
                end else begin
                  valid_reg <= 1'b1; // R18
                  case (post)
                    `DCD_POST_MA: result_reg <= ma_out;
                    `DCD_POST_FIR: result_reg <= fir_out; // R06
                    default: result_reg <= x_reg;
                  endcase
                end
              end
              default: st_reg <= 2'h0;
            endcase
          end
        end
      end

      assign res_all[c*16 +: 16] = result_reg;
      assign valid_all[c] = valid_reg;
      assign ready_all[c] = (skip_reg == `DCD_FIRST_RESULT_SKIP);
      assign publish_all[c] = publish & ~clr;
    end
  endgenerate
endmodule

// File: dcd_front_model.sv
/*
  Front-end model: oversampling clock and two 1-bit modulator streams, with
  the analogue chopper ahead of the modulators.
  Assumes clk is the design clock; the bench picks a pattern per channel.
*/
`timescale 1ns/1ps
module dcd_front_model (
  input wire clk,
  input wire rst_b,
  input wire dechop_clock,
  input wire [1:0] mux_sel,
  input wire ext_temp_resistor_sel,
  input wire [1:0] pat_i,
  input wire [1:0] pat_v,
  output wire oversample_clock,
  output reg [1:0] modulator_bitstream
);
  // patterns: 0 full negative, 1 full positive, 2 alternating
  reg [2:0] div_reg;
  reg alt_reg;
  // ext temp: sensor reads positive, resistor negative, one at a time
  wire [1:0] src_v = (mux_sel == 2'h1) ? {1'b0, ~ext_temp_resistor_sel} : pat_v;
  assign oversample_clock = div_reg[2];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 3'h0;
      alt_reg <= 1'b0;
      modulator_bitstream <= 2'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
      // bits move while the clock is low, so the sampling edge sees them settled
      if (div_reg == 3'h7) begin
        alt_reg <= ~alt_reg;
        // chopper flips the input during the high chop phase
        modulator_bitstream[0] <= (pat_i == 2'h2 ? alt_reg : pat_i[0]) ^ dechop_clock;
        modulator_bitstream[1] <= (src_v == 2'h2 ? alt_reg : src_v[0]) ^ dechop_clock;
      end
    end
  end
endmodule

// File: dcd_top_checker.sv
/*
  Checker of dcd_top: result strobes and hold, first-result latency, gain
  codes, chop disable.
  Assumes a bind to dcd_top with connections by name.
*/
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_top_checker (
  input wire clk,
  input wire rst_b,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire oversample_clock,
  input wire dechop_clock,
  input wire [2:0] pga_gain_i,
  input wire [2:0] pga_gain_v,
  input wire [1:0] mux_sel,
  input wire ext_temp_resistor_sel,
  input wire [15:0] result_i,
  input wire [15:0] result_v,
  input wire result_i_valid,
  input wire result_v_valid
);
  reg [5:0] ctrl_reg;
  reg osc_reg;
  reg rsel_reg;
  reg [1:0] mux_reg;
  reg [7:0] cnt_i_reg;
  reg [7:0] cnt_v_reg;
  wire osc_rise = oversample_clock & ~osc_reg;
  wire v_restart = !ctrl_reg[1] || mux_sel != mux_reg || ext_temp_resistor_sel != rsel_reg;
  // oversample edges since (re)start; saturates, only the low end matters
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `DCD_CTRL_RESET;
      osc_reg <= 1'b0;
      rsel_reg <= 1'b0;
      mux_reg <= 2'h0;
      cnt_i_reg <= 8'h00;
      cnt_v_reg <= 8'h00;
    end else begin
      if (psel && penable && pready && pwrite && paddr == `DCD_ADDR_CTRL)
        ctrl_reg <= pwdata[5:0];
      osc_reg <= oversample_clock;
      rsel_reg <= ext_temp_resistor_sel;
      mux_reg <= mux_sel;
      if (!ctrl_reg[0])
        cnt_i_reg <= 8'h00;
      else if (osc_rise && cnt_i_reg != 8'hff)
        cnt_i_reg <= cnt_i_reg + 8'h01;
      if (v_restart)
        cnt_v_reg <= 8'h00;
      else if (osc_rise && cnt_v_reg != 8'hff)
        cnt_v_reg <= cnt_v_reg + 8'h01;
    end
  end
  default clocking dcd_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_strobe_i: assert property (result_i_valid |=> !result_i_valid)
    else $error("result_i_valid over one cycle");
  a_strobe_v: assert property (result_v_valid |=> !result_v_valid)
    else $error("result_v_valid over one cycle");
  a_hold_i: assert property (!result_i_valid |-> $stable(result_i))
    else $error("result_i moved without strobe");
  a_hold_v: assert property (!result_v_valid |-> $stable(result_v))
    else $error("result_v moved without strobe");
  a_first_i: assert property (result_i_valid |-> cnt_i_reg > 8'h80)
    else $error("result_i too early after enable");
  a_first_v: assert property (result_v_valid |-> cnt_v_reg > 8'h80)
    else $error("result_v too early after restart");
  a_gain_code: assert property (pga_gain_i <= `DCD_GAIN_CODE_MAX &&
    pga_gain_v <= `DCD_GAIN_CODE_MAX) else $error("illegal gain code");
  a_chop_off: assert property (!ctrl_reg[2] && !$past(ctrl_reg[2]) |-> !dechop_clock)
    else $error("dechop clock runs while disabled");
endmodule

// File: dcd_top_tb.sv
/*
  Self-checking bench of dcd_top: an APB master task and one task per scenario.
  Assumes the front-end model and checker files are compiled before it.
*/
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_top_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [1:0] pat_i = 2'h1;
  reg [1:0] pat_v = 2'h1;
  reg [31:0] rd;
  reg err;
  integer error_cnt = 0;
  integer check_count = 0;
  wire [31:0] prdata;
  wire pready, pslverr, osc, dchk, rsel, tcur, vld_i, vld_v;
  wire [1:0] bits;
  wire [1:0] mux;
  wire [2:0] gain_i, gain_v;
  wire [15:0] res_i, res_v;
  always #20 clk = ~clk;
  // 8000 gives chop half periods of 2 and 1 oversample edges
  dcd_top #(.OVERSAMPLE_CLOCK_HZ(8000)) dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oversample_clock(osc), .modulator_bitstream(bits),
    .dechop_clock(dchk), .pga_gain_i(gain_i), .pga_gain_v(gain_v), .mux_sel(mux),
    .ext_temp_resistor_sel(rsel), .temp_current_en(tcur), .result_i(res_i),
    .result_v(res_v), .result_i_valid(vld_i), .result_v_valid(vld_v));
  dcd_front_model fe (.clk(clk), .rst_b(rst_b), .dechop_clock(dchk), .mux_sel(mux),
    .ext_temp_resistor_sel(rsel), .pat_i(pat_i), .pat_v(pat_v),
    .oversample_clock(osc), .modulator_bitstream(bits));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [8*8-1:0] msg);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t %0s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wv(input ch, input integer lim, output integer c);
    begin
      c = 0;
      @(posedge clk);
      while ((ch ? vld_v : vld_i) !== 1'b1 && c < lim) begin
        c = c + 1;
        @(posedge clk);
      end
    end
  endtask
  task tog(output integer t);
    reg p;
    begin
      repeat (16) @(posedge clk);
      t = 0;
      p = dchk;
      repeat (64) begin
        @(posedge clk);
        if (dchk !== p)
          t = t + 1;
        p = dchk;
      end
    end
  endtask
  // conv: clk cycles per conversion, * * 8
  task run(input ch, input [11:0] cfg, input [1:0] m, input integer conv);
    integer c1, c2;
    begin
      apb(1'b1, ch ? `DCD_ADDR_CFG_V : `DCD_ADDR_CFG_I, {20'h0_0000, cfg});
      apb(1'b1, `DCD_ADDR_CTRL, {26'h0, m, 2'b00, ch, ~ch});
      wv(ch, 4 * conv, c1);
      chk(c1 > 2 * conv && c1 <= 3 * conv + 16, 1, "latency");
      chk(ch ? res_v : res_i, 32'h0000_7fff, "value");
      wv(ch, 2 * conv, c2);
      chk(c2 + 1, conv, "period");
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0);
    end
  endtask
  task t_regs;
    integer g;
    begin
      apb(1'b0, `DCD_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0004, "ctrl");
      apb(1'b0, 8'h18, 32'h0);
      chk(err, 1'b1, "unmapped");
      for (g = 0; g < 6; g = g + 1) begin
        apb(1'b1, `DCD_ADDR_CFG_I, g << 9);
        @(posedge clk);
        chk(gain_i, g < 5 ? g : 4, "gain");
      end
      apb(1'b1, `DCD_ADDR_CFG_V, 32'h0000_0600);
      @(posedge clk);
      chk(gain_v, 32'h0000_0003, "gainv");
    end
  endtask
  task t_chop;
    integer t;
    begin
      tog(t);
      chk(t, 4, "chop2k");
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0000_000c);
      tog(t);
      chk(t, 8, "chop4k");
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0);
      tog(t);
      chk(t, 0, "chopoff");
    end
  endtask
  task t_both;
    integer c;
    begin
      pat_i <= 2'h2;
      pat_v <= 2'h0;
      // same ratios on both channels so that both strobes fall in one cycle
      apb(1'b1, `DCD_ADDR_CFG_I, 32'h0);
      apb(1'b1, `DCD_ADDR_CFG_V, 32'h0);
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0000_0003);
      wv(1'b0, 2048, c);
      chk(vld_v, 1'b1, "both");
      chk(res_i, 32'h0, "noise");
      chk(res_v, 32'h0000_8000, "neg");
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0);
      pat_i <= 2'h1;
      pat_v <= 2'h1;
    end
  endtask
  task t_ext;
    integer c;
    begin
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0000_0012);
      wv(1'b1, 2048, c);
      chk(tcur, 1'b1, "cursrc");
      chk(res_v, 32'h0000_7fff, "sensor");
      wv(1'b1, 2048, c);
      chk(c > 1024, 1'b1, "gap");
      chk(res_v, 32'h0000_8000, "resist");
      apb(1'b0, `DCD_ADDR_STATUS, 32'h0);
      chk(rd[2], 1'b1, "subin");
      // late switch: without a restart the pending result would land within a few hundred cycles
      repeat (1200) @(posedge clk);
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0000_0032);
      wv(1'b1, 2048, c);
      chk(c > 1024 && c < 2048, 1'b1, "muxrst");
      apb(1'b1, `DCD_ADDR_CTRL, 32'h0);
    end
  endtask
  task t_post;
    integer m, c;
    reg [63:0] e;
    begin
      for (m = 0; m < 5; m = m + 1) begin
        e = 64'h7fff;
        if (m < 4)
          e = (e * ((2 << m) - 1) * (m == 0 ? `DCD_MA_RECIP_1 : m == 1 ? `DCD_MA_RECIP_3 :
            m == 2 ? `DCD_MA_RECIP_7 : `DCD_MA_RECIP_15)) >> 16;
        apb(1'b1, `DCD_ADDR_CFG_I, m < 4 ? (m << 7) | 32'h20 : 32'h40);
        apb(1'b1, `DCD_ADDR_CTRL, 32'h0000_0001);
        repeat (m < 4 ? (2 << m) + 2 : 6) wv(1'b0, 2048, c);
        chk(res_i, e[31:0], "post");
        apb(1'b1, `DCD_ADDR_CTRL, 32'h0);
      end
    end
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    $display("regs done");
    t_chop;
    $display("chop done");
    run(1'b0, 12'h000, 2'h0, 512);
    run(1'b0, 12'h001, 2'h0, 1024);
    run(1'b0, 12'h004, 2'h0, 2048);
    run(1'b1, 12'h200, 2'h0, 512);
    run(1'b1, 12'h000, 2'h2, 512);
    run(1'b1, 12'h000, 2'h3, 512);
    $display("rates done");
    t_both;
    $display("both done");
    t_ext;
    $display("ext temp done");
    t_post;
    $display("post done");
    end_sim;
  end
endmodule
bind dcd_top dcd_top_checker u_chk (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .oversample_clock(oversample_clock), .dechop_clock(dechop_clock),
  .pga_gain_i(pga_gain_i), .pga_gain_v(pga_gain_v), .mux_sel(mux_sel),
  .ext_temp_resistor_sel(ext_temp_resistor_sel), .result_i(result_i),
  .result_v(result_v), .result_i_valid(result_i_valid), .result_v_valid(result_v_valid));
